// File: pcs_clock_ctrl.sv
// clock generator control/status, multiplier and prescaler registers
// Operation
// (RULE1) reserved bits read zero, writes ignored
// (RULE2) stable reads 0 while start-up counting
// (RULE3) stable 1 when done, disabled, test mode
// (RULE4) lock 0 acquiring, 1 when locked
// (RULE5) loop reset bit holds loop, resets to 1
// (RULE6) osc powerdown clear keeps oscillator running
// (RULE7) mode 0: oscillator stops at clockgen idle
// (RULE8) mode 1: oscillator stops immediately
// (RULE9) loop powerdown bit, resets to 0
// (RULE10) mode 0 bypasses loop, reference drives dividers
// (RULE11) mode 1 feeds dividers from loop output
// (RULE12) multiplier codes 2..15 multiply by value
// (RULE13) software avoids reserved multiplier codes
// (RULE14) prescaler enable bit, resets to 1
// (RULE15) prescaler register sets reference divide ratio
// (RULE16) prescaler divides by field plus one
// (RULE17) software follows bypass/reset/program/relock sequence
// (RULE18) lock drops in reset or powerdown
// (RULE19) mode switch is glitch-free
`timescale 1ns/1ps
`default_nettype none
module pcs_clock_ctrl
    import pcs_pkg::*;
#(
    parameter int OSC_COUNT = pcs_pkg::OSC_START_CYC,
    parameter int LOCK_CYC  = pcs_pkg::LOCK_CYC_DEF
) (
    input  wire logic                     clk,
    input  wire logic                     arst_n,
    input  wire logic [pcs_pkg::ADDR_W-1:0] io_addr,
    input  wire logic [pcs_pkg::DATA_W-1:0] io_wdata,
    input  wire logic                     io_wr,
    input  wire logic                     io_rd,
    output logic      [pcs_pkg::DATA_W-1:0] io_rdata,
    output logic                          io_rvalid,
    input  wire logic                     clock_mode_select_bit,
    input  wire logic                     clockgen_idle_flag,
    input  wire logic                     osc_count_disable,
    input  wire logic                     test_mode,
    input  wire logic                     analog_lock,
    output logic                          loop_reset,
    output logic                          loop_powerdown,
    output logic                          osc_powerdown,
    output logic                          ref_sel_bypass,
    output logic                          pll_sel,
    output logic      [pcs_pkg::FIELD_W-1:0] multiplier_out,
    output logic                          multiplier_valid,
    output logic      [pcs_pkg::FIELD_W-1:0] prescaler_ratio_out,
    output logic                          prescaler_enable_out
);
    import pcs_pkg::*;

    // software-visible state
    logic               loop_reset_bit_reg;
    logic               loop_powerdown_bit_reg;
    logic               osc_powerdown_bit_reg;
    logic               loop_mode_select_reg;
    logic [FIELD_W-1:0] multiplier_field_reg;
    logic [FIELD_W-1:0] prescaler_ratio_field_reg;
    logic               prescaler_enable_reg;

    // output-side state
    logic               osc_off_reg;
    logic               bypass_on_reg;
    logic               pll_on_reg;
    logic [DATA_W-1:0]  rdata_reg;
    logic               rvalid_reg;

    wire  sel_csr   = (io_addr == ADDR_CSR);
    wire  sel_mult  = (io_addr == ADDR_MULT);
    wire  sel_presc = (io_addr == ADDR_PRESC);
    wire  wr_csr    = io_wr && sel_csr;
    wire  wr_mult   = io_wr && sel_mult;
    wire  wr_presc  = io_wr && sel_presc;

    wire  stable;
    wire  locked;
    wire  loop_hold = loop_reset_bit_reg || loop_powerdown_bit_reg;
    wire  loop_restart = wr_mult || wr_presc;

    // power-down request: immediate in mode 1, deferred to idle in mode 0
    wire  osc_off_next = osc_powerdown_bit_reg &&
                         (clock_mode_select_bit || clockgen_idle_flag); // [RULE6] [RULE7] [RULE8]

    // read values, reserved positions tied to zero
    wire [DATA_W-1:0] csr_rd;
    wire [DATA_W-1:0] mult_rd;
    wire [DATA_W-1:0] presc_rd;
    assign csr_rd   = {9'h000, stable, locked, 1'b0, loop_reset_bit_reg, osc_powerdown_bit_reg,
                       loop_powerdown_bit_reg, loop_mode_select_reg}; // [RULE1]
    assign mult_rd  = {11'h000, multiplier_field_reg};                 // [RULE1]
    assign presc_rd = {prescaler_enable_reg, 10'h000, prescaler_ratio_field_reg}; // [RULE1]
    wire [DATA_W-1:0] rd_mux = sel_csr   ? csr_rd   :
                               sel_mult  ? mult_rd  :
                               sel_presc ? presc_rd : ZERO16;

    // glitch-free switch: the new source is enabled only after the old one is off
    wire bypass_next = !loop_mode_select_reg && !pll_on_reg;  // [RULE10] [RULE19]
    wire pll_next    = loop_mode_select_reg && !bypass_on_reg; // [RULE11] [RULE19]

    pcs_osc_counter #(
        .COUNT         (OSC_COUNT)
    ) u_osc (
        .clk           (clk),
        .arst_n        (arst_n),
        .osc_off       (osc_off_reg),
        .count_disable (osc_count_disable),
        .test_mode     (test_mode),
        .stable        (stable)
    );

    pcs_lock_detect #(
        .LOCK_CYC    (LOCK_CYC)
    ) u_lock (
        .clk         (clk),
        .arst_n      (arst_n),
        .loop_hold   (loop_hold),
        .restart     (loop_restart),
        .analog_lock (analog_lock),
        .locked      (locked)
    );

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            loop_reset_bit_reg     <= LRST_RESET;
            osc_powerdown_bit_reg  <= OPD_RESET;
            loop_powerdown_bit_reg <= LPD_RESET;
            loop_mode_select_reg   <= MODE_RESET;
        end else if (wr_csr) begin
            loop_reset_bit_reg     <= io_wdata[CSR_LRST_BIT]; // [RULE5]
            osc_powerdown_bit_reg  <= io_wdata[CSR_OPD_BIT];  // [RULE6]
            loop_powerdown_bit_reg <= io_wdata[CSR_LPD_BIT];  // [RULE9]
            loop_mode_select_reg   <= io_wdata[CSR_MODE_BIT]; // [RULE10]
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            multiplier_field_reg <= MULT_RESET;
        end else if (wr_mult) begin
            multiplier_field_reg <= io_wdata[FIELD_W-1:0]; // [RULE12]
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prescaler_ratio_field_reg <= PRESC_RESET;
            prescaler_enable_reg      <= PRESC_EN_RESET;
        end else if (wr_presc) begin
            prescaler_ratio_field_reg <= io_wdata[FIELD_W-1:0];     // [RULE15] [RULE16]
            prescaler_enable_reg      <= io_wdata[PRESC_EN_BIT];    // [RULE14]
        end
    end

    // both select flops reset to off; bypass comes up one cycle after release
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            osc_off_reg   <= 1'b0;
            bypass_on_reg <= 1'b0;
            pll_on_reg    <= 1'b0;
        end else begin
            osc_off_reg   <= osc_off_next;
            bypass_on_reg <= bypass_next;
            pll_on_reg    <= pll_next;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg  <= ZERO16;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg  <= io_rd ? rd_mux : ZERO16;
            rvalid_reg <= io_rd;
        end
    end

    // registered copies of control state drive the analog side
    logic loop_reset_o_reg;
    logic loop_pd_o_reg;
    logic [FIELD_W-1:0] mult_o_reg;
    logic mult_ok_reg;
    logic [FIELD_W-1:0] presc_o_reg;
    logic presc_en_o_reg;

    // reserved multiplier codes are flagged, not corrected: software owns that choice
    wire mult_ok = (multiplier_field_reg >= MULT_MIN) && (multiplier_field_reg <= MULT_MAX); // [RULE13]

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            loop_reset_o_reg <= LRST_RESET;
            loop_pd_o_reg    <= LPD_RESET;
            mult_o_reg       <= MULT_RESET;
            mult_ok_reg      <= 1'b0;
            presc_o_reg      <= PRESC_RESET;
            presc_en_o_reg   <= PRESC_EN_RESET;
        end else begin
            loop_reset_o_reg <= loop_reset_bit_reg;     // [RULE5]
            loop_pd_o_reg    <= loop_powerdown_bit_reg; // [RULE9]
            mult_o_reg       <= multiplier_field_reg;
            mult_ok_reg      <= mult_ok;
            presc_o_reg      <= prescaler_ratio_field_reg;
            presc_en_o_reg   <= prescaler_enable_reg;
        end
    end

    assign io_rdata             = rdata_reg;
    assign io_rvalid            = rvalid_reg;
    assign loop_reset           = loop_reset_o_reg;
    assign loop_powerdown       = loop_pd_o_reg;
    assign osc_powerdown        = osc_off_reg;
    assign ref_sel_bypass       = bypass_on_reg;
    assign pll_sel              = pll_on_reg;
    assign multiplier_out       = mult_o_reg;
    assign multiplier_valid     = mult_ok_reg;
    assign prescaler_ratio_out  = presc_o_reg;
    assign prescaler_enable_out = presc_en_o_reg;
endmodule : pcs_clock_ctrl
`default_nettype wire

// File: pcs_pkg.sv
// package: register map, field layout, reset values and timing for the clock control block
package pcs_pkg;
    localparam int            ADDR_W          = 16;
    localparam int            DATA_W          = 16;
    localparam logic [15:0]   ADDR_CSR        = 16'h1C80;
    localparam logic [15:0]   ADDR_MULT       = 16'h1C88;
    localparam logic [15:0]   ADDR_PRESC      = 16'h1C8A;
    localparam int            CSR_STABLE_BIT  = 6;
    localparam int            CSR_LOCK_BIT    = 5;
    localparam int            CSR_LRST_BIT    = 3;
    localparam int            CSR_OPD_BIT     = 2;
    localparam int            CSR_LPD_BIT     = 1;
    localparam int            CSR_MODE_BIT    = 0;
    localparam int            PRESC_EN_BIT    = 15;
    localparam int            FIELD_W         = 5;
    localparam logic          LRST_RESET      = 1'b1;
    localparam logic          LPD_RESET       = 1'b0;
    localparam logic          OPD_RESET       = 1'b0;
    localparam logic          MODE_RESET      = 1'b0;
    localparam logic          PRESC_EN_RESET  = 1'b1;
    localparam logic [4:0]    MULT_RESET      = 5'h00;
    localparam logic [4:0]    PRESC_RESET     = 5'h00;
    localparam logic [4:0]    MULT_MIN        = 5'h02;
    localparam logic [4:0]    MULT_MAX        = 5'h0F;
    localparam int            OSC_START_CYC   = 41032;
    localparam int            LOCK_CYC_DEF    = 2000;
    localparam logic [15:0]   ZERO16          = 16'h0000;
endpackage : pcs_pkg

// File: pcs_osc_counter.sv
// oscillator start-up counter producing the stable flag
`timescale 1ns/1ps
`default_nettype none
module pcs_osc_counter #(
    parameter int COUNT = 41032
) (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic osc_off,
    input  wire logic count_disable,
    input  wire logic test_mode,
    output logic      stable
);
    localparam int CW = $clog2(COUNT + 1);
    localparam logic [CW-1:0] LAST = CW'(COUNT);

    logic [CW-1:0] cnt_reg;
    wire           done = (cnt_reg == LAST);

    // a powered-down oscillator must requalify from zero when it restarts
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= '0;
        end else if (osc_off) begin
            cnt_reg <= '0;
        end else if (!done) begin
            cnt_reg <= cnt_reg + CW'(1);
        end
    end

    assign stable = done || count_disable || test_mode; // [RULE2] [RULE3]
endmodule : pcs_osc_counter
`default_nettype wire

// File: pcs_lock_detect.sv
// lock qualification timer: lock rises only after a clean run of the loop
`timescale 1ns/1ps
`default_nettype none
module pcs_lock_detect #(
    parameter int LOCK_CYC = 2000
) (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic loop_hold,
    input  wire logic restart,
    input  wire logic analog_lock,
    output logic      locked
);
    localparam int CW = $clog2(LOCK_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(LOCK_CYC);

    logic [CW-1:0] cnt_reg;

    // a multiplier or prescaler write, a loop hold, or loss of analog lock restarts acquisition
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= '0;
        end else if (loop_hold || restart || !analog_lock) begin
            cnt_reg <= '0; // [RULE18]
        end else if (cnt_reg != LAST) begin
            cnt_reg <= cnt_reg + CW'(1);
        end
    end

    assign locked = (cnt_reg == LAST); // [RULE4]
endmodule : pcs_lock_detect
`default_nettype wire

// File: pcs_clock_ctrl_properties.sv
// checker: port-level properties of the clock control block
`timescale 1ns/1ps
`default_nettype none
module pcs_clock_ctrl_chk
    import pcs_pkg::*;
#(
    parameter int OSC_COUNT = 200,
    parameter int LOCK_CYC  = 10
) (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic [15:0] io_addr,
    input wire logic [15:0] io_wdata,
    input wire logic        io_wr,
    input wire logic        io_rd,
    input wire logic [15:0] io_rdata,
    input wire logic        clock_mode_select_bit,
    input wire logic        clockgen_idle_flag,
    input wire logic        osc_count_disable,
    input wire logic        test_mode,
    input wire logic        loop_reset,
    input wire logic        loop_powerdown,
    input wire logic        osc_powerdown,
    input wire logic        ref_sel_bypass,
    input wire logic        pll_sel,
    input wire logic [4:0]  multiplier_out,
    input wire logic        multiplier_valid,
    input wire logic [4:0]  prescaler_ratio_out,
    input wire logic        prescaler_enable_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire csr_wr  = io_wr && io_addr == ADDR_CSR;
    wire csr_rd  = io_rd && io_addr == ADDR_CSR;
    wire mult_wr = io_wr && io_addr == ADDR_MULT;
    wire psc_wr  = io_wr && io_addr == ADDR_PRESC;
    logic [31:0] cyc_reg;
    // an oscillator restart only delays the flag, so counting from reset is a safe bound
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            cyc_reg <= '0;
        else if (cyc_reg < OSC_COUNT)
            cyc_reg <= cyc_reg + 32'h1;
    end
    sequence csr_hold_s;
        csr_wr ##1 !csr_wr;
    endsequence
    sequence calm_s;
        !(osc_count_disable || test_mode) [*3] ##0 csr_rd;
    endsequence
    sequence forced_s;
        (osc_count_disable || test_mode) [*3] ##0 csr_rd;
    endsequence
    csr_resv_a: assert property (csr_rd |=> io_rdata[15:7] == 0 && !io_rdata[4])
        else $error("reserved control bits read nonzero");
    mult_resv_a: assert property (io_rd && io_addr == ADDR_MULT |=> io_rdata[15:5] == 0)
        else $error("reserved multiplier bits read nonzero");
    stable_early_a: assert property (calm_s ##0 cyc_reg < OSC_COUNT - 2 |=> !io_rdata[6])
        else $error("stable flag set before start-up count");
    stable_force_a: assert property (forced_s |=> io_rdata[6])
        else $error("stable flag not forced");
    lock_drop_a: assert property ((loop_reset || loop_powerdown) && csr_rd |=> !io_rdata[5])
        else $error("lock flag set while loop held");
    ctrl_bits_a: assert property (csr_hold_s |=> loop_reset == $past(io_wdata[3], 2)
        && loop_powerdown == $past(io_wdata[1], 2)) else $error("loop control outputs wrong");
    mode_path_a: assert property (csr_hold_s ##1 !csr_wr |=> pll_sel == $past(io_wdata[0], 3)
        && ref_sel_bypass == !$past(io_wdata[0], 3)) else $error("divider path select wrong");
    mux_excl_a: assert property (!(pll_sel && ref_sel_bypass))
        else $error("both clock paths selected");
    osc_cause_a: assert property ($rose(osc_powerdown) |-> $past(clock_mode_select_bit)
        || $past(clockgen_idle_flag)) else $error("oscillator stopped without cause");
    mult_out_a: assert property (mult_wr ##1 !mult_wr |=> multiplier_out == $past(io_wdata[4:0], 2)
        && multiplier_valid == ($past(io_wdata[4:0], 2) inside {[MULT_MIN:MULT_MAX]}))
        else $error("multiplier output wrong");
    presc_out_a: assert property (psc_wr ##1 !psc_wr |=> prescaler_ratio_out == $past(io_wdata[4:0], 2)
        && prescaler_enable_out == $past(io_wdata[15], 2)) else $error("prescaler output wrong");
endmodule : pcs_clock_ctrl_chk
bind pcs_clock_ctrl pcs_clock_ctrl_chk #(.OSC_COUNT(OSC_COUNT), .LOCK_CYC(LOCK_CYC)) i_pcs_clock_ctrl_chk (.*);
`default_nettype wire

// File: pll_control_status_and_multiplier_test.sv
// testbench: register access, control outputs and status flags
`timescale 1ns/1ps
`default_nettype none
module pll_control_status_and_multiplier_test;
    import pcs_pkg::*;
    localparam int OSC_N  = 200;
    localparam int LOCK_N = 10;
    logic clk = 1'h0, arst_n = 1'h0, io_wr = 1'h0, io_rd = 1'h0, io_rvalid, multiplier_valid, analog_lock = 1'h0;
    logic clock_mode_select_bit = 1'h0, clockgen_idle_flag = 1'h0, osc_count_disable = 1'h0, test_mode = 1'h0;
    logic loop_reset, loop_powerdown, osc_powerdown, ref_sel_bypass, pll_sel, prescaler_enable_out;
    logic [15:0] io_addr = 16'h0000, io_wdata = 16'h0000, io_rdata, d;
    logic [4:0]  multiplier_out, prescaler_ratio_out;
    logic [31:0] seed = 32'h000184C3;
    logic [15:0] exp_q[$];
    int          error_cnt = 0, compares = 0;
    pcs_clock_ctrl #(.OSC_COUNT(OSC_N), .LOCK_CYC(LOCK_N)) i_pcs_clock_ctrl (.*);
    always #2.5 clk = ~clk;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        compares++;
        if (seen !== want) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask : check
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(posedge clk);
        io_addr <= a;
        io_wdata <= v;
        io_wr <= 1'h1;
        @(posedge clk);
        io_wr <= 1'h0;
    endtask : wr
    // the expectation is queued first so the monitor never finds the queue empty
    task automatic rd(input logic [15:0] a, input logic [15:0] want);
        exp_q.push_back(want);
        @(posedge clk);
        io_addr <= a;
        io_rd <= 1'h1;
        @(posedge clk);
        io_rd <= 1'h0;
    endtask : rd
    task automatic settle();
        repeat (3) @(negedge clk);
    endtask : settle
    task automatic print_verdict();
        $display("errors %0d, compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict
    always @(negedge clk)
        if (io_rvalid === 1'h1)
            check(io_rdata, (exp_q.size() > 0) ? exp_q.pop_front() : 16'hXXXX);
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end
    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'h1;
        settle();
        check({loop_reset, prescaler_enable_out, ref_sel_bypass, pll_sel, multiplier_valid}, 16'h001C);
        rd(ADDR_CSR, 16'h0008);
        rd(ADDR_MULT, 16'h0000);
        rd(ADDR_PRESC, 16'h8000);
        wr(16'h1C82, 16'hFFFF);
        rd(16'h1C82, 16'h0000);
        wr(ADDR_CSR, 16'hFFFF);
        rd(ADDR_CSR, 16'h000F);
        settle();
        check({pll_sel, ref_sel_bypass, loop_reset, loop_powerdown, osc_powerdown}, 16'h0016);
        @(posedge clk);
        clockgen_idle_flag <= 1'h1;
        settle();
        check(osc_powerdown, 16'h0001);
        @(posedge clk);
        clockgen_idle_flag <= 1'h0;
        settle();
        check(osc_powerdown, 16'h0000);
        @(posedge clk);
        clock_mode_select_bit <= 1'h1;
        settle();
        check(osc_powerdown, 16'h0001);
        wr(ADDR_CSR, 16'h0000);
        settle();
        check({osc_powerdown, ref_sel_bypass, pll_sel, loop_reset}, 16'h0004);
        @(posedge clk);
        test_mode <= 1'h1;
        settle();
        rd(ADDR_CSR, 16'h0040);
        test_mode <= 1'h0;
        osc_count_disable <= 1'h1;
        settle();
        rd(ADDR_CSR, 16'h0040);
        osc_count_disable <= 1'h0;
        // settings change only with the loop held in bypass and reset
        wr(ADDR_CSR, 16'h0008);
        for (int i = 0; i < 8; i++) begin
            d = 16'(xs());
            d[4:0] = MULT_MIN + 5'(d[3:0] % 4'hE);
            wr(ADDR_MULT, d);
            rd(ADDR_MULT, {11'h000, d[4:0]});
            settle();
            check({multiplier_out, multiplier_valid}, {d[4:0], d[4:0] inside {[MULT_MIN:MULT_MAX]}});
            d = 16'(xs());
            wr(ADDR_PRESC, d);
            rd(ADDR_PRESC, {d[15], 10'h000, d[4:0]});
            settle();
            check({prescaler_enable_out, prescaler_ratio_out}, {d[15], d[4:0]});
        end
        repeat (OSC_N) @(posedge clk); // one microsecond in reset
        wr(ADDR_CSR, 16'h0000);
        analog_lock <= 1'h1;
        repeat (LOCK_N + 8) @(posedge clk);
        rd(ADDR_CSR, 16'h0060);
        wr(ADDR_CSR, 16'h0001);
        settle();
        check({pll_sel, ref_sel_bypass}, 16'h0002);
        rd(ADDR_CSR, 16'h0061);
        wr(ADDR_CSR, 16'h0008);
        rd(ADDR_CSR, 16'h0048);
        wr(ADDR_CSR, 16'h0002);
        rd(ADDR_CSR, 16'h0042);
        wr(ADDR_CSR, 16'h0000);
        rd(ADDR_CSR, 16'h0040);
        repeat (5) @(posedge clk);
        check(16'(exp_q.size()), 16'h0000);
        print_verdict();
    end
endmodule : pll_control_status_and_multiplier_test
`default_nettype wire
